// ---- core/port_ctrl_pkg.sv ----
// shared constants for the per-port ingress and egress control bank
`default_nettype none
package port_ctrl_pkg;
  localparam int          num_ports    = 5;
  localparam int          addr_w       = 8;
  localparam int          data_w       = 8;
  localparam int          vid_w        = 12;
  localparam int          prio_w       = 2;
  localparam int          port_id_w    = 3;

  // register byte addresses, one per port
  localparam logic [7:0]  port1_ingress_egress_control_off = 8'h10;
  localparam logic [7:0]  port2_ingress_egress_control_off = 8'h20;
  localparam logic [7:0]  port3_ingress_egress_control_off = 8'h30;
  localparam logic [7:0]  port4_ingress_egress_control_off = 8'h40;
  localparam logic [7:0]  port5_ingress_egress_control_off = 8'h50;

  // field positions, identical in every port register
  localparam int          storm_en_bit     = 7;
  localparam int          diffserv_en_bit  = 6;
  localparam int          dot1p_en_bit     = 5;
  localparam int          port_prio_hi     = 4;
  localparam int          port_prio_lo     = 3;
  localparam int          tag_insert_bit   = 2;
  localparam int          tag_remove_bit   = 1;
  localparam int          queue_split_bit  = 0;

  localparam logic [7:0]  ctrl_reset_val   = 8'h00;
  localparam logic [7:0]  unmapped_rd_val  = 8'h00;

  // queue split selection seen by the output scheduler
  localparam logic [1:0]  queue_one        = 2'h0;
  localparam logic [1:0]  queue_two        = 2'h1;
  localparam logic [1:0]  queue_four       = 2'h3;
endpackage
`default_nettype wire

// ---- core/prio_resolve.sv ----
// ingress priority resolution for one frame from one port's control byte
`timescale 1ns/1ps
`default_nettype none
module prio_resolve
  import port_ctrl_pkg::*;
(
  input  wire logic [port_ctrl_pkg::data_w-1:0] ctrl,
  input  wire logic                             dscp_hit,
  input  wire logic [port_ctrl_pkg::prio_w-1:0] dscp_prio,
  input  wire logic                             dot1p_hit,
  input  wire logic [port_ctrl_pkg::prio_w-1:0] dot1p_prio,
  output logic      [port_ctrl_pkg::prio_w-1:0] prio
);
  import port_ctrl_pkg::*;

  logic                dscp_use;
  logic                dot1p_use;
  logic [prio_w-1:0]   dscp_part;
  logic [prio_w-1:0]   dot1p_part;

  // a classifier only counts when enabled and it found a priority
  assign dscp_use   = ctrl[diffserv_en_bit] & dscp_hit; // R3
  assign dot1p_use  = ctrl[dot1p_en_bit] & dot1p_hit; // R4
  assign dscp_part  = dscp_use ? dscp_prio : '0;
  assign dot1p_part = dot1p_use ? dot1p_prio : '0;

  always_comb
  begin
    if (dscp_use || dot1p_use)
    begin
      prio = dscp_part | dot1p_part; // R6
    end
    else
    begin
      prio = ctrl[port_prio_hi:port_prio_lo]; // R5
    end
  end
endmodule // prio_resolve
`default_nettype wire

// ---- core/port_ingress_priority_tag_control.sv ----
// per-port control register bank with ingress priority and egress tag logic
//
// Contract
// R1 - five identical 8-bit port registers, 0x10..0x50
// R2 - bit 7 enables broadcast storm protection
// R3 - bit 6 enables DiffServ priority classification
// R4 - bit 5 enables 802.1p priority classification
// R5 - bits 4:3 give fallback port priority queue
// R6 - OR of 802.1p and DSCP overrides port
// R7 - bit 2 inserts tag on untagged egress frames
// R8 - tagged frames untouched; ingress port VID inserted
// R9 - bit 1 strips tag from tagged egress frames
// R10 - untagged frames pass unmodified under removal
// R11 - bit 0 with outer bit selects queues
// R12 - default VIDs come in, go to egress
`timescale 1ns/1ps
`default_nettype none
module port_ingress_priority_tag_control
  import port_ctrl_pkg::*;
#(
  parameter int nports = port_ctrl_pkg::num_ports
)
(
  input  wire logic                                    mclk,
  input  wire logic                                    rst_b,
  input  wire logic [port_ctrl_pkg::addr_w-1:0]        reg_addr,
  input  wire logic                                    reg_wr,
  input  wire logic                                    reg_rd,
  input  wire logic [port_ctrl_pkg::data_w-1:0]        reg_wdata,
  output logic      [port_ctrl_pkg::data_w-1:0]        reg_rdata,
  output logic                                         reg_rvalid,
  input  wire logic [nports*port_ctrl_pkg::vid_w-1:0]  port_vid,
  input  wire logic [nports-1:0]                       split_hi,
  output logic      [nports-1:0]                       storm_en,
  output logic      [2*nports-1:0]                     queue_sel,
  input  wire logic                                    cls_req,
  input  wire logic [port_ctrl_pkg::port_id_w-1:0]     cls_port,
  input  wire logic                                    cls_dscp_hit,
  input  wire logic [port_ctrl_pkg::prio_w-1:0]        cls_dscp_prio,
  input  wire logic                                    cls_dot1p_hit,
  input  wire logic [port_ctrl_pkg::prio_w-1:0]        cls_dot1p_prio,
  output logic                                         cls_ack,
  output logic      [port_ctrl_pkg::prio_w-1:0]        cls_prio,
  input  wire logic                                    eg_req,
  input  wire logic [port_ctrl_pkg::port_id_w-1:0]     eg_in_port,
  input  wire logic [port_ctrl_pkg::port_id_w-1:0]     eg_out_port,
  input  wire logic                                    eg_rx_tagged,
  output logic                                         eg_ack,
  output logic                                         eg_insert,
  output logic                                         eg_remove,
  output logic      [port_ctrl_pkg::vid_w-1:0]         eg_vid
);
  import port_ctrl_pkg::*;

  // the decoder knows only the five mapped offsets
  if (nports != num_ports)
  begin : g_bad_nports
    $error("port count must match the mapped registers");
  end

  // port numbers 1..nports must fit the request port fields
  if ((1 << port_id_w) <= nports)
  begin : g_bad_port_id_w
    $error("port number field too narrow");
  end

  // field positions reach bit 7 of each register
  if (data_w <= storm_en_bit)
  begin : g_bad_data_w
    $error("register narrower than its fields");
  end

  logic [data_w-1:0]    ctrl_ff [nports];
  logic [data_w-1:0]    reg_rdata_ff;
  logic                 reg_rvalid_ff;
  logic                 cls_ack_ff;
  logic [prio_w-1:0]    cls_prio_ff;
  logic                 eg_ack_ff;
  logic                 eg_insert_ff;
  logic                 eg_remove_ff;
  logic [vid_w-1:0]     eg_vid_ff;
  logic [data_w-1:0]    cls_ctrl;
  logic [prio_w-1:0]    nxt_cls_prio;
  logic                 wr_hit;
  logic [2:0]           wr_idx;
  logic                 rd_hit;
  logic [2:0]           rd_idx;
  logic                 cls_ok;
  logic [2:0]           cls_idx;
  logic                 eg_in_ok;
  logic [2:0]           eg_in_idx;
  logic                 eg_out_ok;
  logic [2:0]           eg_out_idx;
  logic                 cls_take;
  logic                 eg_take;

  // register address to port index; offsets sit on 0x10 boundaries
  function automatic logic addr_hit(input logic [addr_w-1:0] a);
    addr_hit = (a == port1_ingress_egress_control_off) ||
               (a == port2_ingress_egress_control_off) ||
               (a == port3_ingress_egress_control_off) ||
               (a == port4_ingress_egress_control_off) ||
               (a == port5_ingress_egress_control_off);
  endfunction

  // index is only trusted after addr_hit, so other addresses do no harm
  function automatic logic [2:0] addr_idx(input logic [addr_w-1:0] a);
    addr_idx = 3'(a[7:4] - 4'h1);
  endfunction

  // ports are numbered 1..5 on the frame interfaces
  function automatic logic port_ok(input logic [port_id_w-1:0] p);
    port_ok = (p != 3'h0) && (32'(p) <= nports);
  endfunction

  function automatic logic [2:0] port_idx(input logic [port_id_w-1:0] p);
    port_idx = 3'(p - 3'h1);
  endfunction

  assign wr_hit     = addr_hit(reg_addr); // R1
  assign wr_idx     = addr_idx(reg_addr);
  assign rd_hit     = addr_hit(reg_addr);
  assign rd_idx     = addr_idx(reg_addr);
  assign cls_ok     = port_ok(cls_port);
  assign cls_idx    = port_idx(cls_port);
  assign eg_in_ok   = port_ok(eg_in_port);
  assign eg_in_idx  = port_idx(eg_in_port);
  assign eg_out_ok  = port_ok(eg_out_port);
  assign eg_out_idx = port_idx(eg_out_port);
  // a request with a bad port number is dropped with no answer
  assign cls_take   = cls_req && cls_ok;
  assign eg_take    = eg_req && eg_in_ok && eg_out_ok;

  // register storage; writes to unmapped addresses are dropped
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < nports; i++)
        ctrl_ff[i] <= ctrl_reset_val;
    end
    else if (reg_wr && wr_hit)
    begin
      ctrl_ff[wr_idx] <= reg_wdata; // R1
    end
  end

  // read answer is a one-cycle pulse one clock after the strobe
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rvalid_ff <= 1'b0;
    end
    else
    begin
      reg_rvalid_ff <= reg_rd; // R1
    end
  end

  // read data holds until the next read; unmapped reads give zero
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata_ff <= unmapped_rd_val;
    end
    else if (reg_rd)
    begin
      reg_rdata_ff <= rd_hit ? ctrl_ff[rd_idx] : unmapped_rd_val; // R1
    end
  end

  // storm enables come straight from the register bits
  always_comb
  begin
    for (int i = 0; i < nports; i++)
    begin
      storm_en[i] = ctrl_ff[i][storm_en_bit]; // R2
    end
  end

  // queue split seen by the scheduler; reserved pairing 10 falls back
  // to one queue rather than guessing at four
  always_comb
  begin
    for (int i = 0; i < nports; i++)
    begin
      unique case ({split_hi[i], ctrl_ff[i][queue_split_bit]})
        2'b01:   queue_sel[2*i +: 2] = queue_two; // R11
        2'b11:   queue_sel[2*i +: 2] = queue_four; // R11
        default: queue_sel[2*i +: 2] = queue_one; // R11
      endcase
    end
  end

  // a bad port reads as the reset value so the resolver stays defined
  assign cls_ctrl = cls_ok ? ctrl_ff[cls_idx] : ctrl_reset_val;

  // resolution is combinational ahead of the answer register
  prio_resolve u_prio_resolve (
    .ctrl       (cls_ctrl),
    .dscp_hit   (cls_dscp_hit),
    .dscp_prio  (cls_dscp_prio),
    .dot1p_hit  (cls_dot1p_hit),
    .dot1p_prio (cls_dot1p_prio),
    .prio       (nxt_cls_prio)
  );

  // ingress classification answer pulse
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cls_ack_ff <= 1'b0;
    end
    else
    begin
      cls_ack_ff <= cls_take;
    end
  end

  // resolved queue holds until the next accepted request
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cls_prio_ff <= '0;
    end
    else if (cls_take)
    begin
      cls_prio_ff <= nxt_cls_prio; // R5 R6
    end
  end

  // egress edits are keyed on the output port's register, while the
  // inserted VID follows the frame's ingress port
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      eg_ack_ff <= 1'b0;
    end
    else
    begin
      eg_ack_ff <= eg_take;
    end
  end

  // already tagged frames are never given a second tag
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      eg_insert_ff <= 1'b0;
    end
    else if (eg_take)
    begin
      eg_insert_ff <= ctrl_ff[eg_out_idx][tag_insert_bit] &&
                      !eg_rx_tagged; // R7 R8
    end
  end

  // untagged frames have nothing to strip and go out as they came
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      eg_remove_ff <= 1'b0;
    end
    else if (eg_take)
    begin
      eg_remove_ff <= ctrl_ff[eg_out_idx][tag_remove_bit] &&
                      eg_rx_tagged; // R9 R10
    end
  end

  // the VID is handed out even when no tag goes in; it only matters
  // while eg_insert is set
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      eg_vid_ff <= '0;
    end
    else if (eg_take)
    begin
      eg_vid_ff <= port_vid[eg_in_idx*vid_w +: vid_w]; // R8 R12
    end
  end

  // outputs come straight from flip-flops, no logic after them
  assign reg_rdata  = reg_rdata_ff;
  assign reg_rvalid = reg_rvalid_ff;
  assign cls_ack    = cls_ack_ff;
  assign cls_prio   = cls_prio_ff;
  assign eg_ack     = eg_ack_ff;
  assign eg_insert  = eg_insert_ff;
  assign eg_remove  = eg_remove_ff;
  assign eg_vid     = eg_vid_ff;
endmodule // port_ingress_priority_tag_control
`default_nettype wire

// ---- verif/port_ctrl_checker_assertions.sv ----
// concurrent checks on the port control bank ports
`timescale 1ns/1ps
`default_nettype none
module port_ctrl_checker
  import port_ctrl_pkg::*;
#(
  parameter int nports = 5
)
(
  input wire logic              mclk,
  input wire logic              rst_b,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic              reg_rvalid,
  input wire logic [7:0]        reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic [nports-1:0] storm_en,
  input wire logic              cls_req,
  input wire logic              cls_ack,
  input wire logic              eg_req,
  input wire logic              eg_rx_tagged,
  input wire logic [2:0]        cls_port,
  input wire logic [2:0]        eg_in_port,
  input wire logic [2:0]        eg_out_port,
  input wire logic [1:0]        cls_prio,
  input wire logic              eg_ack,
  input wire logic              eg_insert,
  input wire logic              eg_remove
);
  // port numbers outside 1..5 are dropped, so they must give no answer
  wire cls_ok = cls_port != 3'h0 && cls_port < 3'h6;
  wire eg_ok  = eg_in_port != 3'h0 && eg_in_port < 3'h6
                && eg_out_port != 3'h0 && eg_out_port < 3'h6;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  property p_rd_ans; reg_rd |=> reg_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read not answered");
  property p_rd_quiet; !reg_rd |=> !reg_rvalid; endproperty
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("read answer without read");
  property p_storm;
    reg_wr && reg_addr == 8'h10 |=> storm_en[0] == $past(reg_wdata[7]);
  endproperty
  a_storm: assert property (p_storm)
    else $error("storm enable does not follow bit 7");
  property p_cls_ack; cls_req && cls_ok |=> cls_ack; endproperty
  a_cls_ack: assert property (p_cls_ack)
    else $error("classify not answered");
  property p_cls_bad; cls_req && !cls_ok |=> !cls_ack; endproperty
  a_cls_bad: assert property (p_cls_bad)
    else $error("bad port classify answered");
  property p_cls_quiet; !cls_req |=> !cls_ack && $stable(cls_prio); endproperty
  a_cls_quiet: assert property (p_cls_quiet)
    else $error("classify result moved without request");
  property p_eg_ins; eg_req && eg_ok && eg_rx_tagged |=> eg_ack && !eg_insert;
  endproperty
  a_eg_ins: assert property (p_eg_ins)
    else $error("tag inserted into tagged frame");
  property p_eg_rem; eg_req && eg_ok && !eg_rx_tagged |=> eg_ack && !eg_remove;
  endproperty
  a_eg_rem: assert property (p_eg_rem)
    else $error("tag removed from untagged frame");
  property p_eg_bad;
    eg_req && !eg_ok |=> !eg_ack && $stable(eg_insert) && $stable(eg_remove);
  endproperty
  a_eg_bad: assert property (p_eg_bad)
    else $error("bad port egress request changed the decision");
endmodule // port_ctrl_checker

bind port_ingress_priority_tag_control port_ctrl_checker #(.nports(nports))
  i_port_ctrl_checker (
  .mclk         (mclk),
  .rst_b        (rst_b),
  .reg_wr       (reg_wr),
  .reg_rd       (reg_rd),
  .reg_rvalid   (reg_rvalid),
  .reg_addr     (reg_addr),
  .reg_wdata    (reg_wdata),
  .storm_en     (storm_en),
  .cls_req      (cls_req),
  .cls_ack      (cls_ack),
  .eg_req       (eg_req),
  .eg_rx_tagged (eg_rx_tagged),
  .cls_port     (cls_port),
  .eg_in_port   (eg_in_port),
  .eg_out_port  (eg_out_port),
  .cls_prio     (cls_prio),
  .eg_ack       (eg_ack),
  .eg_insert    (eg_insert),
  .eg_remove    (eg_remove)
);
`default_nettype wire

// ---- verif/tb_port_ingress_priority_tag_control.sv ----
// self-checking bench for the per-port control bank
`timescale 1ns/1ps
`default_nettype none
module tb_port_ingress_priority_tag_control;
  logic        mclk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [59:0] port_vid = 60'h505404303202101;
  logic [4:0]  split_hi = 5'h1f, storm_en;
  logic [9:0]  queue_sel;
  logic        cls_req = 1'b0, cls_dscp_hit = 1'b0, cls_dot1p_hit = 1'b0;
  logic [2:0]  cls_port = 3'h1, eg_in_port = 3'h1, eg_out_port = 3'h1;
  logic [1:0]  cls_dscp_prio = 2'h0, cls_dot1p_prio = 2'h0, cls_prio;
  logic        eg_req = 1'b0, eg_rx_tagged = 1'b0, reg_rvalid, cls_ack;
  logic        eg_ack, eg_insert, eg_remove;
  logic [11:0] eg_vid;
  int          n_fail = 0, checks_done = 0, p;
  // ctrl, dscp hit/prio, dot1p hit/prio, expected queue
  logic [15:0] rows [8] = '{16'h18bb, 16'h40d6, 16'h28fa, 16'h70bb,
                            16'h706e, 16'h6870, 16'h60c6, 16'h9993};

  always #5 mclk = ~mclk;

  port_ingress_priority_tag_control i_port_ingress_priority_tag_control (
    .mclk           (mclk),
    .rst_b          (rst_b),
    .reg_addr       (reg_addr),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_wdata      (reg_wdata),
    .reg_rdata      (reg_rdata),
    .reg_rvalid     (reg_rvalid),
    .port_vid       (port_vid),
    .split_hi       (split_hi),
    .storm_en       (storm_en),
    .queue_sel      (queue_sel),
    .cls_req        (cls_req),
    .cls_port       (cls_port),
    .cls_dscp_hit   (cls_dscp_hit),
    .cls_dscp_prio  (cls_dscp_prio),
    .cls_dot1p_hit  (cls_dot1p_hit),
    .cls_dot1p_prio (cls_dot1p_prio),
    .cls_ack        (cls_ack),
    .cls_prio       (cls_prio),
    .eg_req         (eg_req),
    .eg_in_port     (eg_in_port),
    .eg_out_port    (eg_out_port),
    .eg_rx_tagged   (eg_rx_tagged),
    .eg_ack         (eg_ack),
    .eg_insert      (eg_insert),
    .eg_remove      (eg_remove),
    .eg_vid         (eg_vid)
  );

  task automatic chk(string nm, logic [11:0] e, logic [11:0] g);
    checks_done++;
    if (g !== e) n_fail++;
    if (g !== e) $display("ERROR %s expected %h seen %h", nm, e, g);
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // read answer comes a fixed single cycle after the strobe is taken
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rvalid", 12'h1, 12'(reg_rvalid));
    chk("reg_rdata", 12'(e), 12'(reg_rdata));
  endtask

  task automatic cls(logic [2:0] pt, logic [5:0] h, logic k, logic [1:0] x);
    @(posedge mclk);
    cls_port <= pt;
    {cls_dscp_hit, cls_dscp_prio, cls_dot1p_hit, cls_dot1p_prio} <= h;
    cls_req <= 1'b1;
    @(posedge mclk);
    cls_req <= 1'b0;
    #1;
    chk("cls_ack", 12'(k), 12'(cls_ack));
    chk("cls_prio", 12'(x), 12'(cls_prio));
  endtask

  // a refused request must leave the held outputs untouched
  task automatic eg(logic [2:0] i, logic [2:0] o, logic t, logic [2:0] x);
    @(posedge mclk);
    eg_in_port <= i;
    eg_out_port <= o;
    eg_rx_tagged <= t;
    eg_req <= 1'b1;
    @(posedge mclk);
    eg_req <= 1'b0;
    #1;
    chk("eg_ack", 12'(x[2]), 12'(eg_ack));
    chk("eg_flags", 12'(x[1:0]), 12'({eg_insert, eg_remove}));
    chk("eg_vid", 12'(i) * 12'h101, eg_vid);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    chk("storm_en", 12'h0, 12'(storm_en));
    chk("queue_sel", 12'h0, 12'(queue_sel));
    for (int i = 1; i < 6; i++)
      rd(8'(i * 16), 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      p = i % 5 + 1;
      wr(8'(p * 16), rows[i][15:8]);
      chk("storm_en", 12'(rows[i][15]), 12'(storm_en[p-1]));
      chk("queue_sel", {10'h0, {2{rows[i][8]}}}, 12'(queue_sel[2*p-2+:2]));
      cls(3'(p), rows[i][7:2], 1'b1, rows[i][1:0]);
      rd(8'(p * 16), rows[i][15:8]);
    end
    for (int b = 6; b < 9; b++)
      cls(3'(b), 6'h3f, 1'b0, 2'h3);
    wr(8'h11, 8'hff);
    rd(8'h11, 8'h00);
    rd(8'h10, 8'h68);
    @(posedge mclk);
    split_hi <= 5'h00;
    wr(8'h10, 8'h01);
    chk("queue_sel", 12'h1, 12'(queue_sel[1:0]));
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h30, {5'h0, k[1], k[1], 1'b0});
      eg(3'(k + 1), 3'h3, k[0], {1'b1, k[1] & !k[0], k[1] & k[0]});
    end
    eg(3'h4, 3'h7, 1'b1, 3'h1);
    wr(8'h10, 8'h80);
    chk("storm_en", 12'h1, 12'(storm_en));
    @(posedge mclk);
    rst_b <= 1'b0;
    #1;
    chk("storm_en", 12'h0, 12'(storm_en));
    chk("cls_prio", 12'h0, 12'(cls_prio));
    chk("eg_flags", 12'h0, 12'({eg_insert, eg_remove}));
    chk("eg_vid", 12'h0, eg_vid);
    @(posedge mclk);
    rst_b <= 1'b1;
    rd(8'h10, 8'h00);
    finish_test();
  end
endmodule // tb_port_ingress_priority_tag_control
`default_nettype wire
